// ==== tb/login_negotiator_checker.sv ====
// Concurrent checks on the negotiator's ports
`timescale 1ns/100ps
module login_negotiator_checker (
    input wire logic                     clk, resetn, login_req, logout,
    input wire logic                     is_responder, login_rjt,
    input wire logic                     rjt_xid_conflict, rjt_ipa_conflict,
    input wire logic                     logged_in, tx_req, c1_active, tx_ok,
    input wire logic                     c1_remove, exch_start, xid_point,
    input wire logic                     assoc_hdr_send,
    input wire logic [1:0]               tx_class,
    input wire login_neg_pkg::feat_set_t feat
);
    import login_neg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire c23_sup = (tx_class == 2'h1 && feat[1].supported) ||
                   (tx_class == 2'h2 && feat[2].supported);
    wire blocked = tx_req && logged_in && c1_active && c23_sup &&
                   !feat[0].intermix;
    a_rjt_responder: assert property (
        login_rjt |-> $past(is_responder)) else $error("originator rejected");
    a_rjt_reason: assert property (
        login_rjt |-> rjt_xid_conflict || rjt_ipa_conflict)
        else $error("reject without reason");
    a_tx_gate: assert property (
        tx_ok |-> tx_req && logged_in &&
            !(tx_class != 2'h0 && c1_active && !feat[0].intermix))
        else $error("frame passed the gate wrongly");
    a_remove_set: assert property (
        blocked |=> c1_remove) else $error("teardown not asked");
    a_remove_clear: assert property (
        !c1_active [*2] |-> !c1_remove) else $error("teardown left standing");
    a_c23_intermix: assert property (
        !feat[1].intermix && !feat[2].intermix)
        else $error("intermix in class 2 or 3");
    a_class3_ack: assert property (
        feat[2].ack_out == ACK_FORM_1 && feat[2].ack_in == ACK_FORM_1)
        else $error("class 3 uses optional ack");
    a_xid_interlock: assert property (
        feat[0].xid_reassign || feat[0].ipa_supply |-> feat[0].interlock)
        else $error("interlock missing");
    a_hdr_cause: assert property (
        assoc_hdr_send |-> $past(exch_start || xid_point))
        else $error("header without event");
    a_feat_hold: assert property (
        logged_in && $past(logged_in) && !$past(login_req) &&
            !$past(login_req, 2) && !$past(logout) |-> $stable(feat))
        else $error("features moved while logged in");
    c_reject: cover property (login_rjt);
    c_teardown: cover property (c1_remove);
    c_header: cover property (assoc_hdr_send);
endmodule
bind login_negotiator login_negotiator_checker i_login_negotiator_checker (
    .clk(clk), .resetn(resetn), .login_req(login_req), .logout(logout),
    .is_responder(is_responder), .login_rjt(login_rjt),
    .rjt_xid_conflict(rjt_xid_conflict), .rjt_ipa_conflict(rjt_ipa_conflict),
    .logged_in(logged_in), .tx_req(tx_req), .c1_active(c1_active),
    .tx_ok(tx_ok), .c1_remove(c1_remove), .exch_start(exch_start),
    .xid_point(xid_point), .assoc_hdr_send(assoc_hdr_send),
    .tx_class(tx_class), .feat(feat));

// ==== tb/login_negotiator_tb.sv ====
// Self-checking bench for login class parameter negotiation
`timescale 1ns/100ps
module login_negotiator_tb;
    import login_neg_pkg::*;
    typedef struct packed {
        logic [31:0] lw0;
        logic [31:0] lw1;
        logic [11:0] pcfg;
        logic        rs;
        logic [10:0] ex;
    } row_t;
    logic        clk = 1'b0, resetn = 1'b0, login_req = 1'b0;
    logic        is_responder = 1'b0, logout = 1'b0, tx_req = 1'b0;
    logic        c1_active = 1'b0, exch_start = 1'b0, xid_point = 1'b0;
    logic        inf_buf_policy = 1'b0;
    logic        ce = 1'b1;
    logic [1:0]  tx_class = 2'h0, exch_class = 2'h0;
    logic [11:0] pcfg = 12'h0;
    svc_set_t    local_svc = '0;
    svc_set_t    peer_svc;
    feat_set_t   feat;
    logic        login_acc, login_rjt, rjt_xid_conflict, rjt_ipa_conflict;
    logic        logged_in, tx_ok, c1_remove, assoc_hdr_send, assoc_hdr_ipa;
    logic        policy_ok;
    int          n_fail = 0;
    int          checks_done = 0;
    // Expect: acc rjt xid ipa, sup mix interlock, ack_out ack_in
    row_t rows [12] = '{
        '{32'hc000_0c00, 32'hc000_0000, 12'hf0f, 1'h1, 11'h46a},
        '{32'h8000_0400, 32'h4000_0000, 12'hf0d, 1'h1, 11'h445},
        '{32'hb800_0000, 32'h0, 12'hf0f, 1'h1, 11'h440},
        '{32'h8000_c000, 32'h0, 12'hf00, 1'h1, 11'h300},
        '{32'h8000_4000, 32'h0, 12'hfc0, 1'h1, 11'h450},
        '{32'h8000_8000, 32'h0, 12'hfc0, 1'h1, 11'h300},
        '{32'h8000_c000, 32'h0, 12'hf00, 1'h0, 11'h440},
        '{32'h8000_4000, 32'h0, 12'hf40, 1'h1, 11'h450},
        '{32'h8000_3000, 32'h0, 12'hf00, 1'h1, 11'h280},
        '{32'h8000_1000, 32'h0, 12'hf10, 1'h1, 11'h450},
        '{32'h8000_1000, 32'h0, 12'hf30, 1'h1, 11'h450},
        '{32'h8000_c000, 32'h0, 12'h900, 1'h1, 11'h400}};
    login_negotiator i_login_negotiator (
        .clk(clk), .resetn(resetn), .ce(ce), .login_req(login_req),
        .is_responder(is_responder), .logout(logout),
        .local_svc(local_svc), .peer_svc(peer_svc), .login_acc(login_acc),
        .login_rjt(login_rjt), .rjt_xid_conflict(rjt_xid_conflict),
        .rjt_ipa_conflict(rjt_ipa_conflict), .logged_in(logged_in),
        .feat(feat), .tx_req(tx_req), .tx_class(tx_class),
        .c1_active(c1_active), .tx_ok(tx_ok), .c1_remove(c1_remove),
        .exch_start(exch_start), .xid_point(xid_point),
        .exch_class(exch_class), .inf_buf_policy(inf_buf_policy),
        .assoc_hdr_send(assoc_hdr_send), .assoc_hdr_ipa(assoc_hdr_ipa),
        .policy_ok(policy_ok));
    peer_port_model i_peer_port_model (
        .valid_mask(pcfg[11:9]), .mix(pcfg[8]), .xid_code(pcfg[7:6]),
        .ipa_code(pcfg[5:4]), .ack_caps(pcfg[3:0]), .peer_svc(peer_svc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // All three local groups carry the same words
    task automatic do_login(input row_t r);
        @(posedge clk);
        local_svc <= {3{32'h0, 32'h0, r.lw1, r.lw0}};
        pcfg <= r.pcfg;
        is_responder <= r.rs;
        login_req <= 1'b1;
        @(posedge clk);
        login_req <= 1'b0;
        @(posedge clk);
        #1;
        chk({login_acc, login_rjt, rjt_xid_conflict, rjt_ipa_conflict},
            r.ex[10:7]);
        if (r.ex[10]) begin
            chk({feat[0].supported, feat[0].intermix, feat[0].interlock,
                 feat[0].ack_out, feat[0].ack_in}, r.ex[6:0]);
        end
    endtask
    task automatic ev(input logic s, input logic x, input logic [1:0] k,
                      input logic [1:0] e);
        @(posedge clk);
        exch_start <= s;
        xid_point <= x;
        exch_class <= k;
        @(posedge clk);
        exch_start <= 1'b0;
        xid_point <= 1'b0;
        #1;
        chk({assoc_hdr_send, assoc_hdr_ipa}, e);
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    // About 95 cycles of tests; some twenty times that before giving up
    initial begin
        #20000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk({logged_in, login_acc, login_rjt, c1_remove, tx_ok}, 0);
        foreach (rows[i]) begin
            do_login(rows[i]);
        end
        // Class 2 frame must wait for class 1 teardown
        do_login(rows[2]);
        @(posedge clk);
        tx_req <= 1'b1;
        tx_class <= 2'h1;
        c1_active <= 1'b1;
        @(posedge clk);
        #1;
        chk({tx_ok, c1_remove}, 2'h1);
        @(posedge clk);
        c1_active <= 1'b0;
        @(posedge clk);
        #1;
        chk({tx_ok, c1_remove}, 2'h2);
        do_login(rows[0]);
        @(posedge clk);
        c1_active <= 1'b1;
        @(posedge clk);
        #1;
        chk({tx_ok, c1_remove}, 2'h2);
        @(posedge clk);
        tx_req <= 1'b0;
        inf_buf_policy <= 1'b1;
        @(posedge clk);
        #1;
        chk(policy_ok, 1);
        @(posedge clk);
        exch_class <= 2'h2;
        @(posedge clk);
        #1;
        chk(policy_ok, 0);
        do_login('{32'h8000_c000, 32'h0, 12'hfc0, 1'h1, 11'h450});
        ev(1'b0, 1'b1, 2'h0, 2'h2);
        ev(1'b0, 1'b1, 2'h2, 2'h0);
        ev(1'b1, 1'b0, 2'h0, 2'h2);
        do_login(rows[9]);
        ev(1'b1, 1'b0, 2'h1, 2'h3);
        ev(1'b0, 1'b1, 2'h0, 2'h0);
        @(posedge clk);
        logout <= 1'b1;
        @(posedge clk);
        logout <= 1'b0;
        @(posedge clk);
        #1;
        chk(logged_in, 0);
        // Frozen enable: an acceptable login offered now leaves no trace
        @(posedge clk);
        ce <= 1'b0;
        login_req <= 1'b1;
        @(posedge clk);
        login_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({logged_in, login_acc}, 2'h0);
        @(posedge clk);
        ce <= 1'b1;
        print_verdict();
    end
endmodule

// ==== tb/peer_port_model.sv ====
// Peer port model: builds the peer's class parameter groups
`timescale 1ns/100ps
module peer_port_model (
    input  wire logic [2:0]         valid_mask, // Classes offered
    input  wire logic               mix,        // Intermix request
    input  wire logic [1:0]         xid_code,   // X_ID reassign field
    input  wire logic [1:0]         ipa_code,   // Initial associator field
    input  wire logic [3:0]         ack_caps,   // Init 0/N, recipient 0/N
    output login_neg_pkg::svc_set_t peer_svc    // Groups seen by the port
);
    import login_neg_pkg::*;
    always_comb begin
        for (int i = 0; i < NUM_CLASSES; i++) begin
            peer_svc[i] = '0;
            peer_svc[i].word0[VALID_BIT] = valid_mask[i];
            peer_svc[i].word0[INTERMIX_BIT] = mix;
            // Meaningless at this login, set to expose leaks
            peer_svc[i].word0[STACK_HI_BIT:SEQ_DLV_BIT] = 3'h7;
            peer_svc[i].word0[XID_HI_BIT:XID_LO_BIT] = xid_code;
            peer_svc[i].word0[IPA_HI_BIT:IPA_LO_BIT] = ipa_code;
            peer_svc[i].word0[INIT_ACK0_BIT] = ack_caps[3];
            peer_svc[i].word0[INIT_ACKN_BIT] = ack_caps[2];
            peer_svc[i].word1[RCPT_ACK0_BIT] = ack_caps[1];
            peer_svc[i].word1[RCPT_ACKN_BIT] = ack_caps[0];
            peer_svc[i].word3 = 32'ha5a5_a5a5;
        end
    end
endmodule

// ==== verilog/login_neg_pkg.sv ====
// Constants, field layouts and types for login class parameter negotiation
package login_neg_pkg;

    localparam int          NUM_CLASSES   = 3;
    localparam int          GROUP_BYTES   = 16;
    localparam logic [1:0]  CLASS1        = 2'h0;
    localparam logic [1:0]  CLASS2        = 2'h1;
    localparam logic [1:0]  CLASS3        = 2'h2;

    // Word 0 service option and initiator control positions
    localparam int          VALID_BIT     = 31;
    localparam int          INTERMIX_BIT  = 30;
    localparam int          STACK_HI_BIT  = 29;
    localparam int          STACK_LO_BIT  = 28;
    localparam int          SEQ_DLV_BIT   = 27;
    localparam int          XID_HI_BIT    = 15;
    localparam int          XID_LO_BIT    = 14;
    localparam int          IPA_HI_BIT    = 13;
    localparam int          IPA_LO_BIT    = 12;
    localparam int          INIT_ACK0_BIT = 11;
    localparam int          INIT_ACKN_BIT = 10;
    // Word 1 recipient control positions
    localparam int          RCPT_ACK0_BIT = 31;
    localparam int          RCPT_ACKN_BIT = 30;

    // Two-bit option field codes
    localparam logic [1:0]  OPT_NOT_SUP   = 2'h0;
    localparam logic [1:0]  OPT_SUP       = 2'h1;
    localparam logic [1:0]  OPT_RSVD      = 2'h2;
    localparam logic [1:0]  OPT_REQ       = 2'h3;

    // One sixteen-byte class parameter group
    typedef struct packed {
        logic [31:0] word3;
        logic [31:0] word2;
        logic [31:0] word1;
        logic [31:0] word0;
    } class_svc_t;

    typedef class_svc_t [NUM_CLASSES-1:0] svc_set_t;

    typedef enum logic [1:0] {
        ACK_FORM_1 = 2'h0,
        ACK_FORM_N = 2'h1,
        ACK_FORM_0 = 2'h2
    } ack_form_t;

    // Negotiated features of one class
    typedef struct packed {
        logic      supported;
        logic      intermix;
        logic      xid_reassign;
        logic      xid_req_local;
        logic      ipa_supply;
        logic      interlock;
        ack_form_t ack_out;
        ack_form_t ack_in;
    } feat_t;

    typedef feat_t [NUM_CLASSES-1:0] feat_set_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_EVAL   = 3'h2,
        ST_LOGGED = 3'h4
    } login_state_t;

endpackage

// ==== verilog/login_negotiator.sv ====
// Per-class service parameter negotiation at port-to-port login
//
// Summary of operation
// R1: A class group with word 0 bit 31 clear is unsupported and ignored.
// R2: Groups map to classes by position: first class 1, second 2, third 3.
// R3: Class 1 intermix works only when both ports set word 0 bit 30.
// R4: Without intermix, drop any class 1 connection before class 2/3 frames.
// R5: In class 2 and 3 word 0 bit 30 is reserved, no intermix meaning.
// R6: Stacked connect-request and sequential delivery bits are disregarded.
// R7: X_ID reassign field: 00 none, 01 supported, 10 reserved, 11 required.
// R8: When reassignment is required, send association header at start/points.
// R9: Responder rejects when one side requires reassignment, other lacks it.
// R10: Negotiated X_ID reassignment also forces X_ID interlock.
// R11: Initial associator field decoded like the reassign field; 11 required.
// R12: A supporting port supplies initial associator header on originating.
// R13: Required or supported initial associator forces interlock in class 1/2.
// R14: Responder rejects when one side requires associator, other lacks it.
// R15: Word 0 bit 11 is initiator ACK_0 ability, classes 1 and 2 only.
// R16: ACK_0 enabled only with initiator word 0 bit 11, recipient word 1 bit 31.
// R17: Enabled ACK_0 is preferred over ACK_N and ACK_1.
// R18: With ACK_0, both ends run infinite buffering, one ACK_0 per sequence.
// R19: Process policy with infinite buffers needs ACK_0; discard allows it.
// R20: ACK_1 is always available; ACK_0 and ACK_N only via login bits.
// R21: Word 0 bit 10 is initiator ACK_N ability, classes 1 and 2 only.
// R22: ACK_N needs initiator bit 10 and recipient word 1 bit 30; beats ACK_1.
// R23: Negotiated results latch at login and hold until logout, new login or reset.
`timescale 1ns/100ps

module login_negotiator (
    input  wire logic                    clk,             // Clock, 100 MHz
    input  wire logic                    resetn,          // Async reset, low
    input  wire logic                    ce,              // Clock enable
    input  wire logic                    login_req,       // Login params valid
    input  wire logic                    is_responder,    // We answer login
    input  wire logic                    logout,          // Drop login state
    input  wire login_neg_pkg::svc_set_t local_svc,       // Our class groups
    input  wire login_neg_pkg::svc_set_t peer_svc,        // Peer class groups
    output logic                         login_acc,       // Accept pulse
    output logic                         login_rjt,       // Reject pulse
    output logic                         rjt_xid_conflict, // Reason: X_ID
    output logic                         rjt_ipa_conflict, // Reason: assoc
    output logic                         logged_in,       // Results valid
    output login_neg_pkg::feat_set_t     feat,            // Latched features
    input  wire logic                    tx_req,          // Frame wants to go
    input  wire logic [1:0]              tx_class,        // Its class index
    input  wire logic                    c1_active,       // Class 1 conn up
    output logic                         tx_ok,           // Frame may go
    output logic                         c1_remove,       // Tear down class 1
    input  wire logic                    exch_start,      // We open exchange
    input  wire logic                    xid_point,       // X_ID reassign here
    input  wire logic [1:0]              exch_class,      // Exchange class
    input  wire logic                    inf_buf_policy,  // Process, inf. buf
    output logic                         assoc_hdr_send,  // Send assoc header
    output logic                         assoc_hdr_ipa,   // With initial value
    output logic                         policy_ok        // Policy usable
);

    import login_neg_pkg::*;

    // Parameters are captured on the edge that takes login_req and judged
    // in the single evaluation cycle after it; the verdict pulse follows.
    // is_responder is read in that evaluation cycle, not at the request.

    function automatic logic opt_supports(input logic [1:0] m);
        // Reserved code counts as no support
        opt_supports = (m == OPT_SUP) || (m == OPT_REQ); // R7 R11
    endfunction

    function automatic logic opt_requires(input logic [1:0] m);
        opt_requires = (m == OPT_REQ); // R7 R11
    endfunction

    function automatic logic opt_conflict(input logic [1:0] a,
                                          input logic [1:0] b);
        opt_conflict = (opt_requires(a) && !opt_supports(b)) ||
                       (opt_requires(b) && !opt_supports(a));
    endfunction

    function automatic logic [1:0] xid_field(input logic [31:0] w);
        xid_field = w[XID_HI_BIT:XID_LO_BIT]; // R7
    endfunction

    function automatic logic [1:0] ipa_field(input logic [31:0] w);
        ipa_field = w[IPA_HI_BIT:IPA_LO_BIT]; // R11
    endfunction

    function automatic logic ack_class(input logic [1:0] cls);
        ack_class = (cls == CLASS1) || (cls == CLASS2); // R15 R21
    endfunction

    // Index 3 names no class; every table lookup is guarded by this
    function automatic logic class_ok(input logic [1:0] cls);
        class_ok = (cls == CLASS1) || (cls == CLASS2) || (cls == CLASS3);
    endfunction

    // Initiator word 0 against recipient word 1 for one direction
    function automatic ack_form_t ack_pick(input logic [1:0]  cls,
                                           input logic [31:0] init_w0,
                                           input logic [31:0] rcpt_w1);
        if (!ack_class(cls)) begin
            ack_pick = ACK_FORM_1; // R20
        end else if (init_w0[INIT_ACK0_BIT] && rcpt_w1[RCPT_ACK0_BIT]) begin
            ack_pick = ACK_FORM_0; // R16 R17 R18
        end else if (init_w0[INIT_ACKN_BIT] && rcpt_w1[RCPT_ACKN_BIT]) begin
            ack_pick = ACK_FORM_N; // R22
        end else begin
            ack_pick = ACK_FORM_1; // R20
        end
    endfunction

    // Bits 29..27 are never read here: no stacked or sequential meaning
    function automatic feat_t eval_class(input logic [1:0]  cls,
                                         input class_svc_t  loc,
                                         input class_svc_t  peer);
        feat_t      f;
        logic       both;
        logic       c12;
        logic [1:0] lx;
        logic [1:0] px;
        logic [1:0] li;
        logic [1:0] pi;
        f    = '0;
        both = loc.word0[VALID_BIT] && peer.word0[VALID_BIT]; // R1
        c12  = ack_class(cls);
        lx   = xid_field(loc.word0);
        px   = xid_field(peer.word0);
        li   = ipa_field(loc.word0);
        pi   = ipa_field(peer.word0);
        if (both) begin
            f.supported     = 1'b1; // R1
            f.intermix      = (cls == CLASS1) && // R5
                              loc.word0[INTERMIX_BIT] &&
                              peer.word0[INTERMIX_BIT]; // R3
            f.xid_reassign  = c12 && opt_supports(lx) &&
                              opt_supports(px); // R7
            f.xid_req_local = c12 && opt_requires(lx); // R8
            f.ipa_supply    = c12 && opt_supports(li) &&
                              opt_supports(pi); // R12
            f.interlock     = f.xid_reassign || f.ipa_supply; // R10 R13
            f.ack_out       = ack_pick(cls, loc.word0, peer.word1);
            f.ack_in        = ack_pick(cls, peer.word0, loc.word1);
        end
        eval_class = f; // R6
    endfunction

    function automatic logic xid_conf(input logic [1:0] cls,
                                      input class_svc_t loc,
                                      input class_svc_t peer);
        xid_conf = ack_class(cls) && loc.word0[VALID_BIT] &&
                   peer.word0[VALID_BIT] &&
                   opt_conflict(xid_field(loc.word0),
                                xid_field(peer.word0)); // R9
    endfunction

    function automatic logic ipa_conf(input logic [1:0] cls,
                                      input class_svc_t loc,
                                      input class_svc_t peer);
        ipa_conf = ack_class(cls) && loc.word0[VALID_BIT] &&
                   peer.word0[VALID_BIT] &&
                   opt_conflict(ipa_field(loc.word0),
                                ipa_field(peer.word0)); // R14
    endfunction

    login_state_t state_q;
    login_state_t state_d;
    svc_set_t     loc_q;
    svc_set_t     loc_d;
    svc_set_t     peer_q;
    svc_set_t     peer_d;
    feat_set_t    feat_q;
    feat_set_t    feat_d;
    feat_set_t    feat_eval;
    feat_t        tx_feat;
    feat_t        ex_feat;
    logic [NUM_CLASSES-1:0] xid_c;
    logic [NUM_CLASSES-1:0] ipa_c;

    // Each output register sits beside its next value
    logic         acc_q;
    logic         acc_d;
    logic         rjt_q;
    logic         rjt_d;
    logic         rjt_xid_q;
    logic         rjt_xid_d;
    logic         rjt_ipa_q;
    logic         rjt_ipa_d;
    logic         c1_remove_q;
    logic         c1_remove_d;
    logic         assoc_q;
    logic         assoc_d;
    logic         assoc_ipa_q;
    logic         assoc_ipa_d;
    logic         policy_q;
    logic         policy_d;

    // Position in the parameter block selects the class
    for (genvar i = 0; i < NUM_CLASSES; i++) begin : g_cls
        assign feat_eval[i] = eval_class(2'(i), loc_q[i], peer_q[i]); // R2
        assign xid_c[i]     = xid_conf(2'(i), loc_q[i], peer_q[i]);
        assign ipa_c[i]     = ipa_conf(2'(i), loc_q[i], peer_q[i]);
    end

    // Only the answering side refuses; an originator leaves it to the peer
    wire   any_xid_c  = |xid_c;
    wire   any_ipa_c  = |ipa_c;
    wire   reject     = is_responder && (any_xid_c || any_ipa_c); // R9 R14
    wire   in_eval    = (state_q == ST_EVAL);
    wire   take_login = login_req && (state_q != ST_EVAL);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (login_req) begin
                    state_d = ST_EVAL;
                end
            end
            ST_EVAL: begin
                // A logout racing the verdict wins: no empty login remains
                if (logout || reject) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_LOGGED;
                end
            end
            ST_LOGGED: begin
                if (logout) begin
                    state_d = ST_IDLE;
                end else if (login_req) begin
                    state_d = ST_EVAL;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Parameters stay put from the taking edge until the next login
    assign loc_d  = take_login ? local_svc : loc_q;
    assign peer_d = take_login ? peer_svc : peer_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            loc_q   <= '0;
            peer_q  <= '0;
        end else if (ce) begin
            state_q <= state_d;
            loc_q   <= loc_d;
            peer_q  <= peer_d;
        end
    end

    // Clearing wins over loading so a refused login leaves nothing behind
    wire   feat_clr = logout || take_login || (in_eval && reject);
    assign feat_d   = feat_clr ? '0 : in_eval ? feat_eval : feat_q; // R23

    // Results are frozen between logins so frame logic never sees a blend
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feat_q <= '0;
        end else if (ce) begin
            feat_q <= feat_d;
        end
    end

    // Reasons only move on an evaluation, so they outlive the pulse
    assign acc_d     = in_eval && !reject && !logout;
    assign rjt_d     = in_eval && reject; // R9 R14
    assign rjt_xid_d = in_eval ? (reject && any_xid_c) : rjt_xid_q; // R9
    assign rjt_ipa_d = in_eval ? (reject && any_ipa_c) : rjt_ipa_q; // R14

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q     <= 1'b0;
            rjt_q     <= 1'b0;
            rjt_xid_q <= 1'b0;
            rjt_ipa_q <= 1'b0;
        end else if (ce) begin
            acc_q     <= acc_d;
            rjt_q     <= rjt_d;
            rjt_xid_q <= rjt_xid_d;
            rjt_ipa_q <= rjt_ipa_d;
        end
    end

    // Frame gating for class 2/3 against a live class 1 connection
    assign tx_feat     = feat_q[class_ok(tx_class) ? tx_class : CLASS1];
    wire   c1_feat_mix = feat_q[CLASS1].intermix;
    wire   tx_is_c1    = (tx_class == CLASS1);
    wire   tx_cls_ok   = class_ok(tx_class) && tx_feat.supported;
    wire   blocked_c1  = !tx_is_c1 && c1_active && !c1_feat_mix; // R4
    wire   tx_held     = tx_req && logged_in && tx_cls_ok;

    // Request stands until the connection is really gone
    assign c1_remove_d = (tx_held && blocked_c1) ||
                         (c1_remove_q && c1_active); // R4

    assign tx_ok = tx_held && !blocked_c1; // R4

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c1_remove_q <= 1'b0;
        end else if (ce) begin
            c1_remove_q <= c1_remove_d;
        end
    end

    // Association header requests per exchange event
    wire   ex_ok      = class_ok(exch_class) && logged_in;
    assign ex_feat    = feat_q[ex_ok ? exch_class : CLASS1];
    wire   hdr_xid    = ex_ok && ex_feat.xid_req_local &&
                        (exch_start || xid_point); // R8
    wire   hdr_ipa    = ex_ok && ex_feat.ipa_supply && exch_start; // R12 R11
    // Process policy with infinite buffers is legal only over ACK_0
    wire   pol_ack0   = ex_ok && (ex_feat.ack_out == ACK_FORM_0); // R19
    assign assoc_d     = hdr_xid || hdr_ipa;
    assign assoc_ipa_d = hdr_ipa;
    assign policy_d    = inf_buf_policy ? pol_ack0 : ex_ok; // R19 R18

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            assoc_q     <= 1'b0;
            assoc_ipa_q <= 1'b0;
            policy_q    <= 1'b0;
        end else if (ce) begin
            assoc_q     <= assoc_d;
            assoc_ipa_q <= assoc_ipa_d;
            policy_q    <= policy_d;
        end
    end

    assign login_acc        = acc_q;
    assign login_rjt        = rjt_q;
    assign rjt_xid_conflict = rjt_xid_q;
    assign rjt_ipa_conflict = rjt_ipa_q;
    assign logged_in        = (state_q == ST_LOGGED);
    assign feat             = feat_q;
    assign c1_remove        = c1_remove_q;
    assign assoc_hdr_send   = assoc_q;
    assign assoc_hdr_ipa    = assoc_ipa_q;
    assign policy_ok        = policy_q;

endmodule
